// >>> logic/tet_timer_event.sv
`timescale 1ns/1ps
// Function
// - Enabled filter passes a new input level only after three stable samples.
// - Filter enable is bit 6 of the shared filter control register.
// - Brown-out reset clears filter enable, so the filter is bypassed.
// - On match, interrupt raised at fourth-quarter edge, flag set next instruction cycle.
// - Rollover to flag set takes at most one instruction cycle in synchronous modes.
// - Prescaled match interrupts on first fourth-quarter edge after count resets.
// - Each match in a synchronous mode emits a trigger pulse timed to end of third quarter.
// - Trigger-reset comes from capture one only in modes 1110 or 1111.
// - Trigger-reset disable bit 6 of timer control blocks the trigger-reset.
// - Accepted trigger-reset clears the count in continuous and single-shot.
// - Single-shot and stopped: capture one edge sets the run bit.
// - After such a start the count advances on the next timer clock.
// - Later period match clears the run bit and stops the timer.
// - Time-out after a capture start emits the trigger output in synchronous modes.
// - Bus write to the count beats a coincident trigger-reset.
// - Sleep-run clear: timer stops in sleep whatever the clock source.
// - Sleep counting only with run, sleep-run, external and bypass set.
// - Match while counting in sleep raises an interrupt that can wake.
// - Asynchronous clocking advances on each timer clock without phase sync.
// - Count reaching period wraps to zero and sets the match flag.
// - Sync counter samples input in second and fourth quarters, rise over three samples.
module tet_timer_event (
    // Clock and resets
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic bor_i,
    // Register port
    input wire logic [tet_pkg::AW-1:0] addr_i,
    input wire logic [tet_pkg::DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [tet_pkg::DW-1:0] rdata_o,
    // Device state and pins
    input wire logic sleep_i,
    input wire logic external_count_input_i,
    input wire logic capture1_input_i,
    // Events
    output logic trig_o,
    output logic irq_o,
    output logic irq_priority_o,
    output logic wake_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [1:0] phase;
    tet_pkg::tet_tcon_t tcon;
    tet_pkg::tet_tcon_t next_tcon;
    logic [tet_pkg::DW-1:0] hbuf;
    logic [15:0] count_value;
    logic [15:0] period_value;
    logic period_match_flag;
    logic period_match_irq_enable;
    logic period_match_irq_priority;
    logic [tet_pkg::CAP_MODE_W-1:0] capture1_mode;
    logic [tet_pkg::FLT_CTL_W-1:0] flt_ctl;
    logic [2:0] ps_cnt;
    logic [2:0] smp;
    logic cnt_pend;
    logic filt_d;
    tet_pkg::tet_ev_state_t state;
    tet_pkg::tet_ev_state_t next_state;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire wr_cnt_hi = wr_i && (addr_i == tet_pkg::ADDR_CNT_HI);
    wire wr_cnt_lo = wr_i && (addr_i == tet_pkg::ADDR_CNT_LO);
    wire wr_per_hi = wr_i && (addr_i == tet_pkg::ADDR_PER_HI);
    wire wr_per_lo = wr_i && (addr_i == tet_pkg::ADDR_PER_LO);
    wire wr_tcon = wr_i && (addr_i == tet_pkg::ADDR_TCON);
    wire wr_prio = wr_i && (addr_i == tet_pkg::ADDR_IRQ_PRIO);
    wire wr_en = wr_i && (addr_i == tet_pkg::ADDR_IRQ_EN);
    wire wr_flag = wr_i && (addr_i == tet_pkg::ADDR_IRQ_FLAG);
    wire wr_cap = wr_i && (addr_i == tet_pkg::ADDR_CAPTURE1_CTL);
    wire wr_flt = wr_i && (addr_i == tet_pkg::ADDR_FLT_CTL);
    wire rd_cnt_lo = rd_i && (addr_i == tet_pkg::ADDR_CNT_LO);

    wire [tet_pkg::DW-1:0] rd_mux =
        (addr_i == tet_pkg::ADDR_CNT_HI) ? hbuf :
        (addr_i == tet_pkg::ADDR_CNT_LO) ? count_value[7:0] :
        (addr_i == tet_pkg::ADDR_PER_HI) ? period_value[15:8] :
        (addr_i == tet_pkg::ADDR_PER_LO) ? period_value[7:0] :
        (addr_i == tet_pkg::ADDR_TCON) ? tcon :
        (addr_i == tet_pkg::ADDR_IRQ_PRIO) ? {7'h00, period_match_irq_priority} :
        (addr_i == tet_pkg::ADDR_IRQ_EN) ? {7'h00, period_match_irq_enable} :
        (addr_i == tet_pkg::ADDR_IRQ_FLAG) ? {7'h00, period_match_flag} :
        (addr_i == tet_pkg::ADDR_CAPTURE1_CTL) ? {4'h0, capture1_mode} :
        (addr_i == tet_pkg::ADDR_FLT_CTL) ? {1'h0, flt_ctl} :
        tet_pkg::RST_BYTE;

    // ----------------------------------------------------------------
    // Input filter and sampling
    // ----------------------------------------------------------------
    wire count_filter_enable = flt_ctl[tet_pkg::FLT_EN_BIT];
    wire filt;

    tet_noise_filter u_filt (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .en_i(count_filter_enable),
        .sample_i(phase == tet_pkg::PH_Q1),
        .din_i(external_count_input_i),
        .dout_o(filt)
    );

    // Synchronous counter samples twice per instruction cycle
    wire smp_now = (phase == tet_pkg::PH_SECOND) || (phase == tet_pkg::PH_FOURTH);
    wire [2:0] smp_next = {smp[1:0], filt};
    wire rise_seen = smp_now && (smp_next == tet_pkg::RISE_PATTERN);

    // ----------------------------------------------------------------
    // Timer clock selection and prescaler
    // ----------------------------------------------------------------
    wire ext_sel = tcon.external_clock_select;
    wire async_mode = ext_sel && tcon.sync_bypass;
    wire at_q1 = (phase == tet_pkg::PH_Q1);
    // Asynchronous mode counts on any core cycle, not only on Q1
    wire clk_evt = !ext_sel ? at_q1 :
                   !tcon.sync_bypass ? (at_q1 && cnt_pend) :
                   (filt && !filt_d);
    // Only the fully asynchronous external path survives sleep
    wire sleep_ok = tcon.timer_run && tcon.sleep_run_enable && async_mode;
    wire run_ok = tcon.timer_run && (!sleep_i || sleep_ok);

    wire cap_mode_ok = (capture1_mode == tet_pkg::CAP_MODE_TRIG_A) ||
                       (capture1_mode == tet_pkg::CAP_MODE_TRIG_B);
    wire trig_reset_ok = capture1_input_i && cap_mode_ok &&
                         !tcon.trigger_reset_disable;
    wire hw_start = trig_reset_ok && tcon.single_shot_select && !tcon.timer_run;

    wire [2:0] ps_mask = tet_pkg::PS_FULL >> (tet_pkg::PS_TOP - tcon.prescale);
    wire ps_full = (ps_cnt & ps_mask) == ps_mask;
    wire tick = run_ok && clk_evt && ps_full;
    wire match_evt = tick && (count_value == period_value);

    // Prescaler restarts on count write, stop or trigger-reset
    wire ps_clr = wr_cnt_lo || !tcon.timer_run || trig_reset_ok;
    wire [2:0] next_ps = ps_clr ? 3'h0 :
                         (run_ok && clk_evt) ? ((ps_cnt + 3'h1) & ps_mask) : ps_cnt;

    // ----------------------------------------------------------------
    // Count, buffers and control
    // ----------------------------------------------------------------
    // A bus write beats the trigger-reset, which beats the wrap
    wire [15:0] next_count =
        wr_cnt_lo ? {hbuf, wdata_i} :
        trig_reset_ok ? tet_pkg::RST_WORD :
        match_evt ? tet_pkg::RST_WORD :
        tick ? count_value + 16'h0001 :
        count_value;

    wire [tet_pkg::DW-1:0] next_hbuf = wr_cnt_hi ? wdata_i :
                                       rd_cnt_lo ? count_value[15:8] : hbuf;

    always_comb begin
        next_tcon = tcon;
        if (wr_tcon) begin
            next_tcon = tet_pkg::tet_tcon_t'(wdata_i);
        end else if (hw_start) begin
            next_tcon.timer_run = 1'h1;
        end else if (match_evt && tcon.single_shot_select) begin
            next_tcon.timer_run = 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Match event sequencer
    // ----------------------------------------------------------------
    // A match seen in the third quarter skips the trigger; that is the
    // asynchronous case, where the trigger is not to be relied on.
    always_comb begin
        next_state = state;
        case (state)
            tet_pkg::EV_IDLE: begin
                if (match_evt) begin
                    next_state = tet_pkg::EV_WAIT_TRIG;
                end
            end
            tet_pkg::EV_WAIT_TRIG: begin
                if (phase == tet_pkg::PH_THIRD) begin
                    next_state = tet_pkg::EV_WAIT_IRQ;
                end else if (phase == tet_pkg::PH_FOURTH) begin
                    next_state = tet_pkg::EV_IDLE;
                end
            end
            tet_pkg::EV_WAIT_IRQ: begin
                if (phase == tet_pkg::PH_FOURTH) begin
                    next_state = tet_pkg::EV_IDLE;
                end
            end
            default: begin
                next_state = tet_pkg::EV_IDLE;
            end
        endcase
    end

    wire next_trig = (state == tet_pkg::EV_WAIT_TRIG) && (phase == tet_pkg::PH_THIRD);
    wire flag_set = (state != tet_pkg::EV_IDLE) && (phase == tet_pkg::PH_FOURTH);
    // Hardware set wins over a software clear in the same cycle
    wire next_flag = flag_set || (wr_flag ? wdata_i[tet_pkg::IRQ_BIT] : period_match_flag);

    // ----------------------------------------------------------------
    // Flip-flops
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            phase <= tet_pkg::PH_Q1;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            smp <= 3'h0;
            cnt_pend <= 1'h0;
            filt_d <= 1'h0;
            ps_cnt <= 3'h0;
        end else begin
            if (smp_now) begin
                smp <= smp_next;
            end
            cnt_pend <= rise_seen || (cnt_pend && !at_q1);
            filt_d <= filt;
            ps_cnt <= next_ps;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            count_value <= tet_pkg::RST_WORD;
            hbuf <= tet_pkg::RST_BYTE;
            tcon <= tet_pkg::tet_tcon_t'(tet_pkg::RST_BYTE);
        end else begin
            count_value <= next_count;
            hbuf <= next_hbuf;
            tcon <= next_tcon;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            period_value <= tet_pkg::PERIOD_RST;
        end else begin
            if (wr_per_hi) begin
                period_value[15:8] <= wdata_i;
            end
            if (wr_per_lo) begin
                period_value[7:0] <= wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            period_match_flag <= 1'h0;
            period_match_irq_enable <= 1'h0;
            period_match_irq_priority <= 1'h0;
            capture1_mode <= 4'h0;
        end else begin
            period_match_flag <= next_flag;
            if (wr_en) begin
                period_match_irq_enable <= wdata_i[tet_pkg::IRQ_BIT];
            end
            if (wr_prio) begin
                period_match_irq_priority <= wdata_i[tet_pkg::IRQ_BIT];
            end
            if (wr_cap) begin
                capture1_mode <= wdata_i[tet_pkg::CAP_MODE_W-1:0];
            end
        end
    end

    // Brown-out takes precedence over a write in the same cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i || bor_i) begin
            flt_ctl <= 7'h00;
        end else if (wr_flt) begin
            flt_ctl <= wdata_i[tet_pkg::FLT_CTL_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= tet_pkg::EV_IDLE;
            trig_o <= 1'h0;
            rdata_o <= tet_pkg::RST_BYTE;
        end else begin
            state <= next_state;
            trig_o <= next_trig;
            rdata_o <= rd_i ? rd_mux : tet_pkg::RST_BYTE;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt outputs
    // ----------------------------------------------------------------
    assign irq_o = period_match_flag && period_match_irq_enable;
    assign irq_priority_o = period_match_irq_priority;
    assign wake_o = irq_o && sleep_i;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    // Brown-out only touches the filter control, and its own check must see it
    default disable iff (rst_i);

    sequence s_sync_match;
        match_evt && at_q1 && (state == tet_pkg::EV_IDLE);
    endsequence

    sequence s_trig_slot;
        !trig_o ##1 !trig_o ##1 trig_o;
    endsequence

    flag_latency_a: assert property (s_sync_match |-> ##4 period_match_flag)
        else $error("match flag later than one instruction cycle");

    trig_timing_a: assert property (s_sync_match |=> s_trig_slot)
        else $error("trigger not at end of third quarter");

    trig_phase_a: assert property ($rose(trig_o) |-> phase == tet_pkg::PH_FOURTH)
        else $error("trigger outside fourth quarter");

    flag_phase_a: assert property ($rose(period_match_flag) && !$past(wr_flag)
                                   |-> phase == tet_pkg::PH_Q1)
        else $error("flag set outside the cycle after fourth quarter");

    wrap_zero_a: assert property (match_evt && !wr_cnt_lo |=> count_value == 16'h0000)
        else $error("count did not wrap on match");

    trig_reset_a: assert property (trig_reset_ok && !wr_cnt_lo |=> count_value == 16'h0000)
        else $error("trigger-reset did not clear count");

    write_wins_a: assert property (wr_cnt_lo && trig_reset_ok
                                   |=> count_value == {$past(hbuf), $past(wdata_i)})
        else $error("trigger-reset beat a bus write");

    hw_start_a: assert property (hw_start && !wr_tcon |=> tcon.timer_run)
        else $error("capture edge did not start timer");

    shot_stop_a: assert property (match_evt && tcon.single_shot_select && !wr_tcon
                                  |=> !tcon.timer_run)
        else $error("single-shot did not stop on match");

    sleep_hold_a: assert property (sleep_i && !sleep_ok && !wr_cnt_lo && !trig_reset_ok
                                   |=> $stable(count_value))
        else $error("count moved in sleep");

    reset_block_a: assert property (capture1_input_i && tcon.trigger_reset_disable
                                    && !wr_cnt_lo && !tick |=> $stable(count_value))
        else $error("disabled trigger-reset acted");

    bor_filter_a: assert property (bor_i ##1 !wr_flt |-> !count_filter_enable)
        else $error("filter still enabled after brown-out");

endmodule : tet_timer_event

// >>> inc/tet_pkg.sv
package tet_pkg;

    // ----------------------------------------------------------------
    // Register port geometry and register indices
    // ----------------------------------------------------------------
    localparam int DW = 8;
    localparam int AW = 4;
    localparam logic [AW-1:0] ADDR_CNT_HI = 4'h0;
    localparam logic [AW-1:0] ADDR_CNT_LO = 4'h1;
    localparam logic [AW-1:0] ADDR_PER_HI = 4'h2;
    localparam logic [AW-1:0] ADDR_PER_LO = 4'h3;
    localparam logic [AW-1:0] ADDR_TCON = 4'h4;
    localparam logic [AW-1:0] ADDR_IRQ_PRIO = 4'h5;
    localparam logic [AW-1:0] ADDR_IRQ_EN = 4'h6;
    localparam logic [AW-1:0] ADDR_IRQ_FLAG = 4'h7;
    localparam logic [AW-1:0] ADDR_CAPTURE1_CTL = 4'h8;
    localparam logic [AW-1:0] ADDR_FLT_CTL = 4'h9;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int IRQ_BIT = 0;
    localparam int FLT_EN_BIT = 6;
    localparam int FLT_CTL_W = 7;
    localparam int CAP_MODE_W = 4;
    localparam logic [DW-1:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [CAP_MODE_W-1:0] CAP_MODE_TRIG_A = 4'he;
    localparam logic [CAP_MODE_W-1:0] CAP_MODE_TRIG_B = 4'hf;

    // ----------------------------------------------------------------
    // Quarter phases, sampling and prescaler
    // ----------------------------------------------------------------
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_SECOND = 2'h1;
    localparam logic [1:0] PH_THIRD = 2'h2;
    localparam logic [1:0] PH_FOURTH = 2'h3;
    localparam int FILT_LEN = 3;
    localparam logic [2:0] RISE_PATTERN = 3'h3;
    localparam logic [2:0] PS_FULL = 3'h7;
    localparam logic [1:0] PS_TOP = 2'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sleep_run_enable;
        logic trigger_reset_disable;
        logic single_shot_select;
        logic [1:0] prescale;
        logic sync_bypass;
        logic external_clock_select;
        logic timer_run;
    } tet_tcon_t;

    typedef enum logic [2:0] {
        EV_IDLE = 3'h1,
        EV_WAIT_TRIG = 3'h2,
        EV_WAIT_IRQ = 3'h4
    } tet_ev_state_t;

endpackage : tet_pkg

// >>> logic/tet_noise_filter.sv
`timescale 1ns/1ps
module tet_noise_filter (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Control
    input wire logic en_i,
    input wire logic sample_i,
    // Level in and out
    input wire logic din_i,
    output logic dout_o
);

    logic [tet_pkg::FILT_LEN-1:0] hist;
    logic next_dout;
    wire stable_hi = &hist;
    wire stable_lo = ~|hist;

    // Bypassed filter follows the pin; enabled one waits for a full stable history
    assign next_dout = !en_i ? din_i :
                       stable_hi ? 1'h1 :
                       stable_lo ? 1'h0 : dout_o;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hist <= '0;
            dout_o <= 1'h0;
        end else begin
            if (sample_i) begin
                hist <= {hist[tet_pkg::FILT_LEN-2:0], din_i};
            end
            dout_o <= next_dout;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    filt_hold_a: assert property (en_i && !stable_hi && !stable_lo |=> $stable(dout_o))
        else $error("filter passed an unstable level");

endmodule : tet_noise_filter

// >>> tb/tet_far_side.sv
`timescale 1ns/1ps
// ----
// Far side: count pulse source and capture pin
// ----
module tet_far_side (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Requests from the bench
    input wire logic go_i,
    input wire logic [7:0] n_i,
    input wire logic [7:0] half_i,
    input wire logic cap_pin_i,
    // Towards the timer, and busy back to the bench
    output logic ext_o,
    output logic cap_o,
    output logic busy_o
);
    logic [7:0] left;
    logic [7:0] tmr;
    logic pin_q;
    assign busy_o = (left != 8'h00);
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            left <= 8'h00;
            tmr <= 8'h00;
            ext_o <= 1'b0;
        end else if (go_i) begin
            left <= n_i;
            tmr <= half_i;
        end else if (busy_o) begin
            if (tmr > 8'h01) begin
                tmr <= tmr - 8'h01;
            end else begin
                // Each level is held half_i cycles; idle level is low
                tmr <= half_i;
                ext_o <= ~ext_o;
                left <= left - {7'h00, ext_o};
            end
        end
    end
    // The pin is a level; the timer wants one pulse per active edge
    always_ff @(posedge mclk_i) begin
        pin_q <= cap_pin_i;
        cap_o <= cap_pin_i & ~pin_q & ~rst_i;
    end
endmodule : tet_far_side

// >>> tb/tet_timer_event_tb_top.sv
`timescale 1ns/1ps
module tet_timer_event_tb_top;
    logic mclk_i, rst_i, bor_i, wr_i, rd_i, sleep_i, go, pin, ext, cap, busy;
    logic trig_o, irq_o, prio_o, wake_o;
    logic [tet_pkg::AW-1:0] addr_i;
    logic [tet_pkg::DW-1:0] wdata_i, rdata_o;
    logic [7:0] n_cnt, half;
    logic [3:0] amap [5] = '{4'h9, 4'h8, 4'h5, 4'h6, 4'ha};
    logic [7:0] emap [5] = '{8'h7f, 8'h0f, 8'h01, 8'h01, 8'h00};
    logic [7:0] mode_v [3] = '{8'h0e, 8'h0f, 8'h0d};
    logic [7:0] expc_v [3] = '{8'h00, 8'h00, 8'h12};
    logic [7:0] slp_v [3] = '{8'h07, 8'h85, 8'h83};
    int errors, total_checks, n;

    tet_timer_event dut (.mclk_i(mclk_i), .rst_i(rst_i), .bor_i(bor_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
        .external_count_input_i(ext), .capture1_input_i(cap), .trig_o(trig_o),
        .irq_o(irq_o), .irq_priority_o(prio_o), .wake_o(wake_o));
    tet_far_side far (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .n_i(n_cnt),
        .half_i(half), .cap_pin_i(pin), .ext_o(ext), .cap_o(cap), .busy_o(busy));

    // ----
    // Tasks
    // ----
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_byte({7'h00, got}, {7'h00, exp}, msg);
    endtask : chk_bit
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr_reg
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk_byte(rdata_o, exp, msg);
    endtask : chk_rd
    task automatic wr_cnt(input logic [15:0] v);
        wr_reg(4'h0, v[15:8]);
        wr_reg(4'h1, v[7:0]);
    endtask : wr_cnt
    task automatic send(input logic [7:0] cnt, input logic [7:0] hp);
        @(posedge mclk_i);
        n_cnt <= cnt;
        half <= hp;
        go <= 1'b1;
        @(posedge mclk_i);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 3000 && busy === 1'b1; i++) @(posedge mclk_i);
        repeat (12) @(posedge mclk_i);
    endtask : send
    task automatic pulse_cap();
        @(posedge mclk_i);
        pin <= 1'b1;
        @(posedge mclk_i);
        pin <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask : pulse_cap
    task automatic wait_trig();
        #1;
        n = 0;
        while (trig_o !== 1'b1 && n < 400) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        if (n >= 400) begin
            errors++;
            $display("[FAIL] %0t no trigger pulse", $time);
        end
    endtask : wait_trig
    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, errors);
    endtask : done
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----
    // Clock, watchdog and tests
    // ----
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        tally_and_finish();
    end
    initial begin
        errors = 0;
        total_checks = 0;
        {rst_i, bor_i, wr_i, rd_i, sleep_i, go, pin} = 7'h40;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        n_cnt = 8'h00;
        half = 8'h01;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        chk_rd(4'h4, 8'h00, "control reset");
        chk_rd(4'h2, 8'hff, "period hi reset");
        chk_rd(4'h3, 8'hff, "period lo reset");
        chk_rd(4'h1, 8'h00, "count reset");
        for (int i = 0; i < 5; i++) begin
            wr_reg(amap[i], 8'hff);
            chk_rd(amap[i], emap[i], "register access");
        end
        chk_bit(prio_o, 1'b1, "priority pin");
        done("registers");
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h3, 8'h03);
        wr_cnt(16'h0000);
        wr_reg(4'h7, 8'h00);
        wr_reg(4'h4, 8'h01);
        wait_trig();
        chk_bit(irq_o, 1'b0, "flag before trigger");
        @(posedge mclk_i);
        #1;
        chk_bit(trig_o, 1'b0, "trigger one cycle");
        chk_bit(irq_o, 1'b1, "flag after trigger");
        // Trigger is only relied on in synchronous modes
        for (int ps = 0; ps < 4; ps++) begin
            wr_reg(4'h4, {3'h0, 2'(ps), 3'h1});
            wait_trig();
            @(posedge mclk_i);
            wait_trig();
            chk_byte(n[7:0], 8'((16 << ps) - 1), "match spacing");
        end
        done("match");
        wr_reg(4'h2, 8'hff);
        wr_reg(4'h3, 8'hff);
        wr_reg(4'h4, 8'h03);
        wr_reg(4'h9, 8'h40);
        wr_cnt(16'h0000);
        send(8'h03, 8'h03);
        chk_rd(4'h1, 8'h00, "glitches filtered");
        send(8'h03, 8'h10);
        chk_rd(4'h1, 8'h03, "steady pulses");
        wr_reg(4'h9, 8'h00);
        wr_cnt(16'h0000);
        send(8'h03, 8'h04);
        chk_rd(4'h1, 8'h03, "sync counting");
        wr_reg(4'h9, 8'h40);
        @(posedge mclk_i);
        bor_i <= 1'b1;
        @(posedge mclk_i);
        bor_i <= 1'b0;
        chk_rd(4'h9, 8'h00, "brown-out clear");
        done("filter");
        wr_reg(4'h4, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr_reg(4'h8, mode_v[i]);
            wr_cnt(16'h0012);
            pulse_cap();
            chk_rd(4'h1, expc_v[i], "trigger reset mode");
        end
        wr_reg(4'h4, 8'h40);
        wr_reg(4'h8, 8'h0e);
        wr_cnt(16'h0012);
        pulse_cap();
        chk_rd(4'h1, 8'h12, "trigger reset disabled");
        wr_reg(4'h4, 8'h00);
        @(posedge mclk_i);
        pin <= 1'b1;
        wr_reg(4'h1, 8'h34);
        pin <= 1'b0;
        chk_rd(4'h1, 8'h34, "write beats reset");
        done("trigger reset");
        wr_reg(4'h4, 8'h20);
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h3, 8'h10);
        wr_cnt(16'h0005);
        pulse_cap();
        chk_rd(4'h4, 8'h21, "started by edge");
        wait_trig();
        chk_bit(n > 50, 1'b1, "count cleared at start");
        chk_rd(4'h4, 8'h20, "stopped at time-out");
        chk_rd(4'h1, 8'h00, "count after time-out");
        done("single shot");
        wr_reg(4'h3, 8'h03);
        wr_cnt(16'h0000);
        wr_reg(4'h7, 8'h00);
        wr_reg(4'h4, 8'h87);
        @(posedge mclk_i);
        sleep_i <= 1'b1;
        send(8'h04, 8'h03);
        chk_bit(wake_o, 1'b1, "wake in sleep");
        @(posedge mclk_i);
        sleep_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk_bit(wake_o, 1'b0, "wake after sleep");
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            sleep_i <= 1'b1;
            wr_reg(4'h4, slp_v[i]);
            wr_cnt(16'h0000);
            send(8'h03, 8'h04);
            chk_rd(4'h1, 8'h00, "stopped in sleep");
            sleep_i <= 1'b0;
        end
        done("sleep");
        tally_and_finish();
    end
endmodule : tet_timer_event_tb_top
